// >>> rtl/spcr_consts.svh
`ifndef SPCR_CONSTS_SVH
`define SPCR_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SPCR_OFS_CON1 8'h00
`define SPCR_OFS_CTRL 8'h04
`define SPCR_OFS_TXDATA 8'h08
`define SPCR_OFS_RXDATA 8'h0C
`define SPCR_OFS_STATUS 8'h10

// ----------------------------------------
// Control one fields
// ----------------------------------------
`define SPCR_CON1_W 13
`define SPCR_SMP_BIT 9
`define SPCR_CKE_BIT 8
`define SPCR_SLAVE_SELECT_ENABLE_BIT 7
`define SPCR_CKP_BIT 6
`define SPCR_MASTER_ROLE_ENABLE_BIT 5
`define SPCR_SPRE_HI 4
`define SPCR_SPRE_LO 2
`define SPCR_PPRE_HI 1
`define SPCR_PPRE_LO 0

// ----------------------------------------
// Own control and status fields
// ----------------------------------------
`define SPCR_EN_BIT 0
`define SPCR_FRM_BIT 1
`define SPCR_ST_BUSY_BIT 0
`define SPCR_ST_TXFULL_BIT 1
`define SPCR_ST_RXVALID_BIT 2
`define SPCR_ST_OVF_BIT 3
`define SPCR_ST_SSUSE_BIT 4

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define SPCR_CON1_RST 13'h0000
`define SPCR_FRAME_BITS 4'h8
`define SPCR_HALVES 5'h10
`define SPCR_FIFO_DEPTH 16
`define SPCR_WORD_W 8

`endif

// >>> rtl/spcr_pkg.sv
`include "spcr_consts.svh"

package spcr_pkg;

  typedef enum logic [1:0] {
    SPCR_M_IDLE = 2'b01,
    SPCR_M_RUN = 2'b10
  } spcr_mstate_e;

  typedef struct packed {
    logic [`SPCR_CON1_W-1:0] con1;
    logic en;
    logic frm;
    logic [7:0] tx_buf;
    logic tx_full;
    logic ovf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    spcr_mstate_e mst;
    logic [5:0] div;
    logic [4:0] half;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic [3:0] cnt;
    logic start;
    logic sck_o;
    logic sck_oe;
    logic sdo_o;
    logic sdo_oe;
    logic ss_use;
    logic [1:0] sck_s;
    logic [1:0] sdi_s;
    logic [1:0] ss_s;
    logic sck_d;
    logic push;
    logic [7:0] push_data;
  } spcr_state_s;

endpackage

// >>> rtl/spcr_top.sv
`timescale 1ns/1ns
// How it works
// - Master samples input at end of output time or earlier, per sample phase.
// - Slave select enable one uses the select pin in slave role; zero ignores it.
// - Clock polarity zero idles low; one idles high.
// - Master role enable one generates clock; zero receives the clock.

// ----------------------------------------
// Receive FIFO
// ----------------------------------------
module spcr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp;
  logic [AW:0] rp;
  logic full;
  logic empty;

  assign empty = (wp == rp);
  assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign wr_ready = !full;
  assign rd_valid = !empty;
  assign rd_data = mem[rp[AW-1:0]];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (wr_valid && !full) begin
        wp <= wp + 1'b1;
      end
      if (rd_ready && !empty) begin
        rp <= rp + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (wr_valid && !full) begin
      mem[wp[AW-1:0]] <= wr_data;
    end
  end
endmodule

// ----------------------------------------
// Port top
// ----------------------------------------
module spcr_top
  import spcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic slave_select_pin_n,
  output logic slave_select_in_use
);
  spcr_state_s s;
  spcr_state_s n;
  logic rd_pop;
  logic rx_ready;
  logic rx_valid;
  logic [7:0] rx_data;
  logic [5:0] half_len;
  logic cke_eff;
  logic clock_idle_polarity;
  logic master;
  logic slave_on;
  logic sel;
  logic lead;
  logic trail;
  logic smp_edge;
  logic chg_edge;
  logic offs;
  logic [4:0] rel;

  spcr_fifo #(.WIDTH(`SPCR_WORD_W), .DEPTH(`SPCR_FIFO_DEPTH)) u_rx_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .wr_valid(s.push),
    .wr_ready(rx_ready),
    .wr_data(s.push_data),
    .rd_valid(rx_valid),
    .rd_ready(rd_pop),
    .rd_data(rx_data)
  );

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign sck_out = s.sck_o;
  assign sck_oe = s.sck_oe;
  assign sdo = s.sdo_o;
  assign sdo_oe = s.sdo_oe;
  assign slave_select_in_use = s.ss_use;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = s;
    rd_pop = 1'b0;
    clock_idle_polarity = s.con1[`SPCR_CKP_BIT];
    master = s.con1[`SPCR_MASTER_ROLE_ENABLE_BIT];
    cke_eff = s.con1[`SPCR_CKE_BIT] && !s.frm;
    offs = !cke_eff;
    half_len = 6'(3'd4 - {1'b0, s.con1[`SPCR_PPRE_HI:`SPCR_PPRE_LO]})
      * 6'(4'd8 - {1'b0, s.con1[`SPCR_SPRE_HI:`SPCR_SPRE_LO]});
    rel = s.half - 5'(offs);
    n.sck_s = {s.sck_s[0], sck_in};
    n.sdi_s = {s.sdi_s[0], sdi};
    n.ss_s = {s.ss_s[0], slave_select_pin_n};
    n.sck_d = s.sck_s[1];
    n.push = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    slave_on = s.en && !master && (s.mst == SPCR_M_IDLE);
    sel = s.con1[`SPCR_SLAVE_SELECT_ENABLE_BIT] ? !s.ss_s[1] : 1'b1;
    lead = (s.sck_s[1] != s.sck_d) && (s.sck_s[1] == !clock_idle_polarity);
    trail = (s.sck_s[1] != s.sck_d) && (s.sck_s[1] == clock_idle_polarity);
    smp_edge = cke_eff ? lead : trail;
    chg_edge = cke_eff ? trail : lead;

    // ----------------------------------------
    // Register access
    // ----------------------------------------
    if (psel && penable && !s.pready) begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      case (paddr)
        `SPCR_OFS_CON1: begin
          if (pwrite) begin
            n.con1 = pwdata[`SPCR_CON1_W-1:0];
          end else begin
            n.prdata = {19'h0_0000, s.con1};
          end
        end
        `SPCR_OFS_CTRL: begin
          if (pwrite) begin
            n.en = pwdata[`SPCR_EN_BIT];
            n.frm = pwdata[`SPCR_FRM_BIT];
          end else begin
            n.prdata[`SPCR_EN_BIT] = s.en;
            n.prdata[`SPCR_FRM_BIT] = s.frm;
          end
        end
        `SPCR_OFS_TXDATA: begin
          if (pwrite) begin
            if (s.tx_full) begin
              n.pready = 1'b0;
            end else begin
              n.tx_buf = pwdata[7:0];
              n.tx_full = 1'b1;
            end
          end else begin
            n.prdata = {24'h00_0000, s.tx_buf};
          end
        end
        `SPCR_OFS_RXDATA: begin
          if (!pwrite && rx_valid) begin
            n.prdata = {24'h00_0000, rx_data};
            rd_pop = 1'b1;
          end
        end
        `SPCR_OFS_STATUS: begin
          if (pwrite) begin
            if (pwdata[`SPCR_ST_OVF_BIT]) begin
              n.ovf = 1'b0;
            end
          end else begin
            n.prdata[`SPCR_ST_BUSY_BIT] = (s.mst == SPCR_M_RUN);
            n.prdata[`SPCR_ST_TXFULL_BIT] = s.tx_full;
            n.prdata[`SPCR_ST_RXVALID_BIT] = rx_valid;
            n.prdata[`SPCR_ST_OVF_BIT] = s.ovf;
            n.prdata[`SPCR_ST_SSUSE_BIT] = s.ss_use;
          end
        end
        default: begin
          n.pslverr = 1'b1;
        end
      endcase
    end

    // ----------------------------------------
    // Master engine
    // ----------------------------------------
    case (s.mst)
      SPCR_M_IDLE: begin
        if (s.en && master) begin
          n.sck_o = clock_idle_polarity;
          if (s.tx_full && rx_ready) begin
            n.mst = SPCR_M_RUN;
            n.tx_sh = s.tx_buf;
            n.tx_full = 1'b0;
            n.half = 5'h00;
            n.div = 6'h00;
            if (cke_eff) begin
              n.sdo_o = s.tx_buf[7];
            end
          end
        end
      end
      SPCR_M_RUN: begin
        if (s.div == half_len - 6'h01) begin
          n.div = 6'h00;
          if (s.half < `SPCR_HALVES) begin
            n.sck_o = !s.sck_o;
          end
          if (offs && s.half == 5'h00) begin
            n.sdo_o = s.tx_sh[7];
          end else if (rel[0]) begin
            n.tx_sh = {s.tx_sh[6:0], 1'b0};
            n.sdo_o = s.tx_sh[6];
          end
          if (s.half >= 5'(offs) && rel[0] == s.con1[`SPCR_SMP_BIT]) begin
            n.rx_sh = {s.rx_sh[6:0], s.sdi_s[1]};
          end
          if (s.half == `SPCR_HALVES - 5'h01 + 5'(offs)) begin
            n.mst = SPCR_M_IDLE;
            n.push = 1'b1;
            n.push_data = n.rx_sh;
          end else begin
            n.half = s.half + 5'h01;
          end
        end else begin
          n.div = s.div + 6'h01;
        end
      end
      default: begin
        n.mst = SPCR_M_IDLE;
      end
    endcase

    // ----------------------------------------
    // Slave engine
    // ----------------------------------------
    if (!slave_on || !sel) begin
      n.cnt = cke_eff ? 4'h0 : `SPCR_FRAME_BITS;
      n.start = cke_eff;
    end else if (s.start) begin
      n.start = 1'b0;
      n.tx_sh = s.tx_full ? s.tx_buf : 8'h00;
      n.tx_full = 1'b0;
    end else if (chg_edge) begin
      if (s.cnt == `SPCR_FRAME_BITS) begin
        n.tx_sh = s.tx_full ? s.tx_buf : 8'h00;
        n.tx_full = 1'b0;
        n.cnt = 4'h0;
      end else begin
        n.tx_sh = {s.tx_sh[6:0], 1'b0};
      end
    end else if (smp_edge && s.cnt != `SPCR_FRAME_BITS) begin
      n.rx_sh = {s.rx_sh[6:0], s.sdi_s[1]};
      n.cnt = s.cnt + 4'h1;
      if (s.cnt == `SPCR_FRAME_BITS - 4'h1) begin
        n.push = 1'b1;
        n.push_data = {s.rx_sh[6:0], s.sdi_s[1]};
        if (!rx_ready) begin
          n.ovf = 1'b1;
        end
      end
    end
    if (slave_on) begin
      n.sdo_o = n.tx_sh[7];
    end

    // ----------------------------------------
    // Pin ownership
    // ----------------------------------------
    n.sck_oe = s.en && master;
    n.sdo_oe = s.en && (master || sel);
    n.ss_use = s.en && !master && s.con1[`SPCR_SLAVE_SELECT_ENABLE_BIT];
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{con1: `SPCR_CON1_RST, mst: SPCR_M_IDLE, start: 1'b1, default: '0};
    end else begin
      s <= n;
    end
  end
endmodule

// >>> verification/spcr_sva.sv
`timescale 1ns/1ns
// ------
// Port checks
// ------
module spcr_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic slave_select_pin_n,
  input wire logic slave_select_in_use
);
  logic [12:0] cfg;
  logic en;
  logic frm;
  logic [1:0] age;
  wire st = age == 2'h3;
  wire lead = sck_out != cfg[6];
  wire cke = cfg[8] & !frm;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '0;
      en <= 1'b0;
      frm <= 1'b0;
      age <= '0;
    end else if (psel && penable && pready && pwrite && paddr < 8'h08) begin
      age <= '0;
      if (paddr[2]) begin
        en <= pwdata[0];
        frm <= pwdata[1];
      end else begin
        cfg <= pwdata[12:0];
      end
    end else if (!st) begin
      age <= age + 2'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence back_idle;
    ##[1:33] sck_out == cfg[6];
  endsequence
  chk_role_clock: assert property (st |-> sck_oe == (en & cfg[5]))
    else $error("clock drive wrong");
  chk_select_use: assert property (
    st |-> slave_select_in_use == (en & !cfg[5] & cfg[7]))
    else $error("select use wrong");
  chk_free_drive: assert property (st && en && (cfg[5] || !cfg[7]) |-> sdo_oe)
    else $error("data out not driven");
  chk_deselect_out: assert property (
    (st && en && !cfg[5] && cfg[7] && slave_select_pin_n)[*4] |-> !sdo_oe)
    else $error("data out driven unselected");
  chk_active_bound: assert property (st && sck_oe && lead |-> back_idle)
    else $error("clock not back at idle");
  chk_edge_data: assert property (
    st && sck_oe && $changed(sck_out) && lead == cke |-> $stable(sdo))
    else $error("data moved on sample edge");
  chk_enable_idle: assert property ($rose(sck_oe) |-> ##[0:2] sck_out == cfg[6])
    else $error("clock idle level wrong");
endmodule

bind spcr_top spcr_sva u_spcr_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .sck_out, .sck_oe, .sdo, .sdo_oe, .slave_select_pin_n,
  .slave_select_in_use);

// >>> verification/spcr_peer.sv
`timescale 1ns/1ns
// ------
// Slave peer
// ------
module spcr_peer (
  input wire logic sck,
  input wire logic run,
  input wire logic cpol,
  input wire logic cke,
  input wire logic load,
  input wire logic mosi,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  logic [7:0] sh;
  int n;
  initial miso = 1'b0;
  task automatic put();
    miso = n < 8 ? sh[7] : ~miso;
    sh = sh << 1;
    n++;
  endtask
  always @(posedge load) begin
    sh = tx_byte;
    n = 0;
    if (cke) put();
  end
  always @(sck) begin
    if (run && (sck != cpol) == cke) rx_byte = {rx_byte[6:0], mosi};
    else if (run) put();
  end
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ns
// ------
// Bench
// ------
module testbench;
  typedef struct {logic [12:0] cfg; logic en; logic [3:0] x;} spcr_row_s;
  localparam logic [7:0] SB = 8'h4B;
  logic pclk, presetn, psel, penable, pwrite, sck_in, sdi, ss_n, load, cpol, cke, e;
  logic pready, pslverr, sck_out, sck_oe, sdo, sdo_oe, ssu, miso;
  logic [7:0] paddr, pb, rxp, sb;
  logic [31:0] pwdata, prdata, r;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  spcr_row_s rows[6] = '{'{13'h0000, 1'b1, 4'h1}, '{13'h0080, 1'b1, 4'h4},
    '{13'h0020, 1'b1, 4'h9}, '{13'h0060, 1'b1, 4'hB}, '{13'h00A0, 1'b1, 4'h9},
    '{13'h1FF2, 1'b0, 4'h0}};
  logic [13:0] md[4] = '{14'h013A, 14'h027A, 14'h003A, 14'h217A};
  spcr_top u_spcr_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sck_in, .sck_out, .sck_oe, .sdi(sck_oe ? miso : sdi),
    .sdo, .sdo_oe, .slave_select_pin_n(ss_n), .slave_select_in_use(ssu));
  spcr_peer u_spcr_peer (.sck(sck_out), .run(sck_oe), .cpol, .cke, .load, .mosi(sdo),
    .tx_byte(pb), .miso, .rx_byte(rxp));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    forever begin
      @(negedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task automatic idle();
    do apb(1'b0, 8'h10, 32'h0); while (r[1:0] !== 2'h0);
  endtask
  task automatic send(input logic [7:0] b);
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    apb(1'b1, 8'h08, 32'(b));
  endtask
  initial begin
    {psel, penable, pwrite, sck_in, sdi, load, cpol, cke} = '0;
    {paddr, pwdata, pb} = '0;
    ss_n = 1'b1;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    chk(32'({sck_out, sck_oe, sdo_oe, ssu}), 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, 8'h00, 32'(rows[i].cfg));
      apb(1'b1, 8'h04, 32'(rows[i].en));
      repeat (4) @(posedge pclk);
      chk(32'({sck_oe, ssu, sck_oe & sck_out, sdo_oe}), 32'(rows[i].x));
      rd(8'h00, 32'(rows[i].cfg));
      rd(8'h10, 32'({rows[i].x[2], 4'h0}));
    end
    foreach (md[i]) begin
      cpol <= md[i][6];
      cke <= md[i][8] & !md[i][13];
      pb <= 8'h96 ^ 8'(i);
      apb(1'b1, 8'h00, 32'(md[i][12:0])); // Prescalers never both 1:1
      apb(1'b1, 8'h04, 32'({md[i][13], 1'b1}));
      send(8'hC3 ^ 8'(i));
      idle();
      chk(32'(rxp), 32'(8'hC3 ^ 8'(i)));
      rd(8'h0C, 32'(pb));
    end
    repeat (16) begin
      send(8'h11);
      idle();
    end
    send(8'h22);
    repeat (100) @(posedge pclk);
    rd(8'h10, 32'h6);
    repeat (16) rd(8'h0C, 32'(pb));
    idle();
    rd(8'h0C, 32'(pb));
    rd(8'h0C, 32'h0);
    chk(32'(rxp), 32'h22);
    rd(8'h14, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h00, 32'h0180);
    apb(1'b1, 8'h08, 32'hA6);
    ss_n <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(32'(sdo_oe), 32'h1);
    for (int j = 7; j >= 0; j--) begin
      sdi <= SB[j];
      repeat (8) @(posedge pclk);
      sck_in <= 1'b1;
      sb[j] = sdo;
      repeat (8) @(posedge pclk);
      sck_in <= 1'b0;
    end
    sdi <= ~sdi;
    ss_n <= 1'b1;
    chk(32'(sb), 32'hA6);
    rd(8'h0C, 32'(SB));
    complete_run();
  end
endmodule
